//--- mgmt_assertions.sv
// concurrent checks on the management link between station and device
`timescale 1ns/1ns
module mgmt_assertions (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic mdc,
    input wire logic sta_mdio_o,
    input wire logic sta_mdio_oe,
    input wire logic dev_mdio_o,
    input wire logic dev_mdio_oe,
    input wire logic mdio
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic [8:0] oe_cnt_q;

    ////////////////////////////////////////////////////////////////////////////////
    // length of a device drive burst; a drift here would shift every read bit
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            oe_cnt_q <= 9'h0;
        else if (dev_mdio_oe)
            oe_cnt_q <= oe_cnt_q + 9'h1;
        else
            oe_cnt_q <= 9'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clock shape: neither half shorter than the 12 MHz limit allows
    AST_MDC_HIGH: assert property ($rose(mdc) |-> mdc [*5])
        else $error("management clock high phase too short");
    AST_MDC_LOW: assert property ($fell(mdc) |-> !mdc [*5])
        else $error("management clock low phase too short");
    // the line is shared, so two drivers at once means contention
    AST_ONE_DRIVER: assert property (!(sta_mdio_oe && dev_mdio_oe))
        else $error("station and device drive the data line together");
    AST_STA_LAUNCH: assert property ($changed(sta_mdio_o) |-> !mdc)
        else $error("station data changed while the clock was high");
    AST_SAMPLE_STABLE: assert property ($rose(mdc) |-> $stable(mdio) ##1 $stable(mdio))
        else $error("data line moved around a clock rise");
    AST_TA_ZERO: assert property ($rose(dev_mdio_oe) |-> !dev_mdio_o && !$past(sta_mdio_oe, 5))
        else $error("read turnaround not released then driven low");
    AST_DRIVE_LEN: assert property ($fell(dev_mdio_oe) |-> oe_cnt_q inside {[9'h0a9:9'h0ab]})
        else $error("device drive burst not seventeen bit periods");
    AST_IDLE_GAP: assert property ($rose(sta_mdio_oe) |-> $past(mdio) && $past(mdio, 10))
        else $error("frame started without an idle bit before it");

    COV_READ: cover property ($fell(dev_mdio_oe));
    COV_FRAME: cover property ($rose(sta_mdio_oe));
    COV_ZERO_BIT: cover property (sta_mdio_oe && !sta_mdio_o && mdc);
endmodule

//--- mgmt_if.sv
// management link between station and device, with the data line pull-up
`timescale 1ns/1ns
interface mgmt_if;
    logic mdc;
    logic sta_mdio_o;
    logic sta_mdio_oe;
    logic dev_mdio_o;
    logic dev_mdio_oe;
    logic mdio;

    // resolved data line; released means pulled high
    assign mdio = dev_mdio_oe ? dev_mdio_o : (sta_mdio_oe ? sta_mdio_o : 1'b1);

    modport station (output mdc, output sta_mdio_o, output sta_mdio_oe, input mdio);
    modport phy     (input mdc, output dev_mdio_o, output dev_mdio_oe, input mdio);
endinterface

//--- mgmt_phy_port.sv
// device end: strap sampling and clause 22 management slave
// Behaviour
// - sample strap shortly after reset release
// - strap tie decodes into two bits
// - address bit0 from bit0, select from xor
// - address bits four to one held zero
// - select starts zero, shown at 24.13 page2
// - software may write select, not address
// - station clock stopped up to 12 MHz
// - data line bidirectional, timed by mdc
// - frame: start, op, addresses, turnaround, data
// - frames without preamble accepted after one idle bit
// - station leaves one idle bit between frames
// - follows published clause 22 frame format
// - page select register 22 on every page
`timescale 1ns/1ns
module mgmt_phy_port (
    input  wire logic        clk,
    input  wire logic        arst_n,
    mgmt_if.phy              m,
    input  wire logic        strap_pin,
    output logic             indicator_out_0,
    output logic             indicator_out_1,
    output logic             indicator_out_2,
    output logic [4:0]       station_address,
    output logic             io_voltage_select,
    output logic             strap_done,
    output logic [7:0]       acc_page,
    output logic [4:0]       acc_reg,
    output logic             acc_rd,
    output logic             acc_wr,
    output logic [15:0]      acc_wdata,
    input  wire logic [15:0] acc_rdata
);

    typedef struct packed {
        logic                  mdc_s1;
        logic                  mdc_s2;
        logic                  mdc_s3;
        logic                  dio_s1;
        logic                  dio_s2;
        logic                  strap_s1;
        logic                  strap_s2;
        mgmt_pkg::strap_st_e   sst;
        logic [7:0]            scnt;
        logic                  strap_a;
        logic                  ind0;
        logic                  ind1;
        logic                  ind2;
        logic                  addr0;
        logic                  iosel;
        logic                  done;
        mgmt_pkg::frame_st_e   fst;
        logic                  prev_bit;
        logic [4:0]            cnt;
        logic [11:0]           hdr;
        logic                  act;
        logic                  rd;
        logic [4:0]            rreg;
        logic [15:0]           sh;
        logic [7:0]            page;
        logic                  dout;
        logic                  doe;
        logic [7:0]            a_page;
        logic [4:0]            a_reg;
        logic                  a_rd;
        logic                  a_wr;
        logic [15:0]           a_wdata;
    } state_s;

    state_s q;
    state_s d;

    // true when a register lives in this block instead of the access port
    function automatic logic is_local(input logic [4:0] r, input logic [7:0] p);
        is_local = (r == mgmt_pkg::REG_PAGE_SEL) ||
                   (r == mgmt_pkg::REG_IO_CTRL && p == mgmt_pkg::PAGE_IO_CTRL);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic        rise;
        logic        b;
        logic [11:0] hdr_n;
        logic [15:0] sh_n;
        rise  = 1'b0;
        b     = 1'b0;
        hdr_n = '0;
        sh_n  = '0;
        d = q;
        d.a_rd = 1'b0;
        d.a_wr = 1'b0;

        // two-flop synchronisers; edge found between second and third stage
        d.mdc_s1   = m.mdc;
        d.mdc_s2   = q.mdc_s1;
        d.mdc_s3   = q.mdc_s2;
        d.dio_s1   = m.mdio;
        d.dio_s2   = q.dio_s1;
        d.strap_s1 = strap_pin;
        d.strap_s2 = q.strap_s1;
        rise = q.mdc_s2 & ~q.mdc_s3;
        b    = q.dio_s2;

        // strap: drive indicator 0 then indicator 1 and watch the pin each time;
        // the pin follows whichever output or rail it is tied to
        unique case (q.sst)
            mgmt_pkg::SS_WAIT: begin
                if (q.scnt == 8'(mgmt_pkg::STRAP_DELAY_CYC - 1)) begin
                    d.sst  = mgmt_pkg::SS_A;
                    d.scnt = '0;
                    d.ind0 = 1'b1;
                end else begin
                    d.scnt = q.scnt + 8'h01;
                end
            end
            mgmt_pkg::SS_A: begin
                if (q.scnt == 8'(mgmt_pkg::STRAP_SETTLE_CYC - 1)) begin
                    d.strap_a = q.strap_s2;
                    d.sst     = mgmt_pkg::SS_B;
                    d.scnt    = '0;
                    d.ind0    = 1'b0;
                    d.ind1    = 1'b1;
                end else begin
                    d.scnt = q.scnt + 8'h01;
                end
            end
            mgmt_pkg::SS_B: begin
                if (q.scnt == 8'(mgmt_pkg::STRAP_SETTLE_CYC - 1)) begin
                    d.sst   = mgmt_pkg::SS_DONE;
                    d.ind1  = 1'b0;
                    d.addr0 = q.strap_a;
                    d.iosel = q.strap_a ^ q.strap_s2;
                    d.done  = 1'b1;
                end else begin
                    d.scnt = q.scnt + 8'h01;
                end
            end
            mgmt_pkg::SS_DONE: begin
            end
        endcase

        // frame receiver; no preamble needed, one idle one then start
        if (rise) begin
            unique case (q.fst)
                mgmt_pkg::F_IDLE: begin
                    d.prev_bit = b;
                    if (q.prev_bit && !b) begin
                        d.fst = mgmt_pkg::F_START;
                    end
                end
                mgmt_pkg::F_START: begin
                    d.prev_bit = b;
                    d.cnt      = '0;
                    d.fst      = b ? mgmt_pkg::F_HDR : mgmt_pkg::F_IDLE;
                end
                mgmt_pkg::F_HDR: begin
                    hdr_n = {q.hdr[10:0], b};
                    d.hdr = hdr_n;
                    if (q.cnt == 5'(mgmt_pkg::HDR_BITS - 1)) begin
                        d.cnt  = '0;
                        d.fst  = mgmt_pkg::F_TA;
                        d.rd   = (hdr_n[11:10] == mgmt_pkg::OP_RD);
                        d.rreg = hdr_n[4:0];
                        d.act  = (hdr_n[9:5] == {mgmt_pkg::ADDR_HI, q.addr0}) &&
                                 (hdr_n[11:10] == mgmt_pkg::OP_RD ||
                                  hdr_n[11:10] == mgmt_pkg::OP_WR);
                        d.a_page = q.page;
                        d.a_reg  = hdr_n[4:0];
                        if (d.act && d.rd && !is_local(hdr_n[4:0], q.page)) begin
                            d.a_rd = 1'b1;
                        end
                    end else begin
                        d.cnt = q.cnt + 5'h01;
                    end
                end
                mgmt_pkg::F_TA: begin
                    if (q.cnt == 5'h00) begin
                        d.cnt = 5'h01;
                        if (q.act && q.rd) begin
                            // second turnaround bit is driven low by us
                            d.doe  = 1'b1;
                            d.dout = 1'b0;
                            if (q.rreg == mgmt_pkg::REG_PAGE_SEL) begin
                                d.sh = {8'h00, q.page};
                            end else if (is_local(q.rreg, q.page)) begin
                                d.sh = 16'(q.iosel) << mgmt_pkg::IOSEL_BIT;
                            end else begin
                                d.sh = acc_rdata;
                            end
                        end
                    end else begin
                        d.cnt = '0;
                        d.fst = mgmt_pkg::F_DATA;
                        if (q.act && q.rd) begin
                            d.dout = q.sh[15];
                            d.sh   = {q.sh[14:0], 1'b0};
                        end
                    end
                end
                mgmt_pkg::F_DATA: begin
                    sh_n = {q.sh[14:0], b};
                    if (q.act && q.rd) begin
                        d.dout = q.sh[15];
                        d.sh   = {q.sh[14:0], 1'b0};
                    end else begin
                        d.sh = sh_n;
                    end
                    if (q.cnt == 5'(mgmt_pkg::DATA_BITS - 1)) begin
                        // release after the last data bit; next frame needs an idle one
                        d.doe      = 1'b0;
                        d.fst      = mgmt_pkg::F_IDLE;
                        d.prev_bit = 1'b0;
                        if (q.act && !q.rd) begin
                            if (q.rreg == mgmt_pkg::REG_PAGE_SEL) begin
                                d.page = sh_n[7:0];
                            end else if (is_local(q.rreg, q.page)) begin
                                d.iosel = sh_n[mgmt_pkg::IOSEL_BIT];
                            end else begin
                                d.a_wr    = 1'b1;
                                d.a_wdata = sh_n;
                            end
                        end
                    end else begin
                        d.cnt = q.cnt + 5'h01;
                    end
                end
                default: begin
                    d.fst = mgmt_pkg::F_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; select reads 3.3V class until the strap is taken
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q          <= '0;
            q.sst      <= mgmt_pkg::SS_WAIT;
            q.fst      <= mgmt_pkg::F_IDLE;
            q.prev_bit <= 1'b0;
            q.iosel    <= 1'b0;
            q.page     <= mgmt_pkg::PAGE_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register
    assign m.dev_mdio_o      = q.dout;
    assign m.dev_mdio_oe     = q.doe;
    assign indicator_out_0   = q.ind0;
    assign indicator_out_1   = q.ind1;
    assign indicator_out_2   = q.ind2; // never set: unused for strapping
    assign station_address   = {mgmt_pkg::ADDR_HI, q.addr0};
    assign io_voltage_select = q.iosel;
    assign strap_done        = q.done;
    assign acc_page          = q.a_page;
    assign acc_reg           = q.a_reg;
    assign acc_rd            = q.a_rd;
    assign acc_wr            = q.a_wr;
    assign acc_wdata         = q.a_wdata;

endmodule

//--- mgmt_pkg.sv
// shared constants and state types for the management port and strap logic
package mgmt_pkg;

    // clock and timing
    localparam int CLK_HZ          = 100_000_000;
    localparam int CLK_NS          = 10;
    localparam int MDC_MAX_HZ      = 12_000_000;
    // least half period of the management clock, rounded up to whole cycles
    localparam int MDC_HALF_CYC    = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
    localparam int STRAP_DELAY_NS  = 1000;
    localparam int STRAP_SETTLE_NS = 200;
    localparam int STRAP_DELAY_CYC  = (STRAP_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_NS - 1) / CLK_NS;

    // frame layout
    localparam int PRE_BITS  = 32;
    localparam int HDR_BITS  = 12;
    localparam int TA_BITS   = 2;
    localparam int DATA_BITS = 16;
    localparam logic [1:0] START_CODE = 2'h1;
    localparam logic [1:0] OP_RD      = 2'h2;
    localparam logic [1:0] OP_WR      = 2'h1;

    // addressing
    localparam logic [3:0] ADDR_HI      = 4'h0;
    localparam logic [4:0] REG_PAGE_SEL = 5'h16;
    localparam logic [4:0] REG_IO_CTRL  = 5'h18;
    localparam logic [7:0] PAGE_IO_CTRL = 8'h02;
    localparam int         IOSEL_BIT    = 13;
    localparam logic [7:0] PAGE_RST     = 8'h00;

    typedef enum logic [1:0] {SS_WAIT, SS_A, SS_B, SS_DONE} strap_st_e;
    typedef enum logic [2:0] {F_IDLE, F_START, F_HDR, F_TA, F_DATA} frame_st_e;
    typedef enum logic [2:0] {P_IDLE, P_GAP, P_PRE, P_HDR, P_TA, P_DATA} sta_st_e;

endpackage

//--- mgmt_station.sv
// station end: makes the management clock and runs clause 22 frames
`timescale 1ns/1ns
module mgmt_station (
    input  wire logic        clk,
    input  wire logic        arst_n,
    mgmt_if.station          m,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic        preamble,
    input  wire logic [4:0]  phy_addr,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] wdata,
    output logic             busy,
    output logic             done,
    output logic [15:0]      rdata
);

    typedef struct packed {
        logic                s1;
        logic                s2;
        mgmt_pkg::sta_st_e   st;
        logic [3:0]          phase;
        logic [5:0]          cnt;
        logic                we;
        logic                pre;
        logic [13:0]         hdr;
        logic [15:0]         sh;
        logic                mdc;
        logic                o;
        logic                oe;
        logic                busy;
        logic                done;
        logic [15:0]         rdata;
    } state_s;

    state_s q;
    state_s d;

    ////////////////////////////////////////////////////////////////////////////
    // bit slot: fall and new drive at phase 0, rise and sample at half period;
    // setting data at the fall gives the device a half period of setup
    always_comb begin
        d = q;
        d.s1   = m.mdio;
        d.s2   = q.s1;
        d.done = 1'b0;
        if (q.st == mgmt_pkg::P_IDLE) begin
            if (req) begin
                d.st    = mgmt_pkg::P_GAP;
                d.phase = '0;
                d.cnt   = '0;
                d.we    = we;
                d.pre   = preamble;
                d.hdr   = {mgmt_pkg::START_CODE, we ? mgmt_pkg::OP_WR : mgmt_pkg::OP_RD,
                           phy_addr, reg_addr};
                d.sh    = wdata;
                d.busy  = 1'b1;
            end
        end else if (q.phase == 4'(mgmt_pkg::MDC_HALF_CYC - 1)) begin
            d.phase = q.phase + 4'h1;
            d.mdc   = 1'b1;
            if (q.st == mgmt_pkg::P_DATA && !q.we) begin
                d.sh = {q.sh[14:0], q.s2}; // sample read data at the rise
            end
        end else if (q.phase == 4'(2 * mgmt_pkg::MDC_HALF_CYC - 1)) begin
            d.phase = '0;
            d.mdc   = 1'b0;
            unique case (q.st)
                mgmt_pkg::P_GAP: begin
                    d.st = q.pre ? mgmt_pkg::P_PRE : mgmt_pkg::P_HDR;
                end
                mgmt_pkg::P_PRE: begin
                    d.cnt = q.cnt + 6'h01;
                    if (q.cnt == 6'(mgmt_pkg::PRE_BITS - 1)) begin
                        d.st  = mgmt_pkg::P_HDR;
                        d.cnt = '0;
                    end
                end
                mgmt_pkg::P_HDR: begin
                    d.hdr = {q.hdr[12:0], 1'b0};
                    d.cnt = q.cnt + 6'h01;
                    if (q.cnt == 6'(mgmt_pkg::HDR_BITS + 1)) begin
                        d.st  = mgmt_pkg::P_TA;
                        d.cnt = '0;
                    end
                end
                mgmt_pkg::P_TA: begin
                    d.cnt = q.cnt + 6'h01;
                    if (q.cnt == 6'(mgmt_pkg::TA_BITS - 1)) begin
                        d.st  = mgmt_pkg::P_DATA;
                        d.cnt = '0;
                    end
                end
                mgmt_pkg::P_DATA: begin
                    d.cnt = q.cnt + 6'h01;
                    if (q.we) begin
                        d.sh = {q.sh[14:0], 1'b0};
                    end
                    if (q.cnt == 6'(mgmt_pkg::DATA_BITS - 1)) begin
                        d.st   = mgmt_pkg::P_IDLE;
                        d.busy = 1'b0;
                        d.done = 1'b1;
                        d.rdata = q.sh;
                    end
                end
                default: begin
                    d.st = mgmt_pkg::P_IDLE;
                end
            endcase
        end else begin
            d.phase = q.phase + 4'h1;
        end

        // drive for the slot about to begin; released during gap and read answer
        unique case (d.st)
            mgmt_pkg::P_PRE: begin
                d.oe = 1'b1;
                d.o  = 1'b1;
            end
            mgmt_pkg::P_HDR: begin
                d.oe = 1'b1;
                d.o  = d.hdr[13];
            end
            mgmt_pkg::P_TA: begin
                d.oe = d.we;
                d.o  = (d.cnt == 6'h00);
            end
            mgmt_pkg::P_DATA: begin
                d.oe = d.we;
                // a read shifts at the rise; hold the idle level so the pin never moves then
                d.o  = d.we ? d.sh[15] : 1'b1;
            end
            default: begin
                d.oe = 1'b0;
                d.o  = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q    <= '0;
            q.st <= mgmt_pkg::P_IDLE;
            q.o  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign m.mdc         = q.mdc;
    assign m.sta_mdio_o  = q.o;
    assign m.sta_mdio_oe = q.oe;
    assign busy          = q.busy;
    assign done          = q.done;
    assign rdata         = q.rdata;

endmodule

//--- strap_config_and_mgmt_port_test.sv
// testbench joining station and device ends over the management link
`timescale 1ns/1ns
`define CHECK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module strap_config_and_mgmt_port_test;
    logic        clk;
    logic        arst_n;
    logic [1:0]  strap_mode;
    logic        strap_pin;
    logic        req;
    logic        we;
    logic        preamble;
    logic [4:0]  phy_addr;
    logic [4:0]  reg_addr;
    logic [15:0] wdata;
    logic        busy;
    logic        done;
    logic [15:0] rdata;
    logic        ind0, ind1, ind2;
    logic [4:0]  st_addr;
    logic [4:0]  own;
    logic        io_sel, strap_done;
    logic [7:0]  acc_page;
    logic [4:0]  acc_reg;
    logic        acc_rd, acc_wr;
    logic [15:0] acc_wdata, acc_rdata;
    logic [63:0] line_q;
    int          mdc_rises, rd_cnt, wr_cnt, fail_count, checked;

    mgmt_if u_mgmt_if ();
    mgmt_station u_mgmt_station (.clk(clk), .arst_n(arst_n), .m(u_mgmt_if), .req(req),
        .we(we), .preamble(preamble), .phy_addr(phy_addr), .reg_addr(reg_addr),
        .wdata(wdata), .busy(busy), .done(done), .rdata(rdata));
    mgmt_phy_port u_mgmt_phy_port (.clk(clk), .arst_n(arst_n), .m(u_mgmt_if),
        .strap_pin(strap_pin), .indicator_out_0(ind0), .indicator_out_1(ind1),
        .indicator_out_2(ind2), .station_address(st_addr), .io_voltage_select(io_sel),
        .strap_done(strap_done), .acc_page(acc_page), .acc_reg(acc_reg), .acc_rd(acc_rd),
        .acc_wr(acc_wr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata));
    mgmt_assertions u_mgmt_assertions (.clk(clk), .arst_n(arst_n), .mdc(u_mgmt_if.mdc),
        .sta_mdio_o(u_mgmt_if.sta_mdio_o), .sta_mdio_oe(u_mgmt_if.sta_mdio_oe),
        .dev_mdio_o(u_mgmt_if.dev_mdio_o), .dev_mdio_oe(u_mgmt_if.dev_mdio_oe),
        .mdio(u_mgmt_if.mdio));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and the board tie of the strap pin
    initial clk = 1'b0;
    always #5 clk = ~clk;
    always_comb begin
        case (strap_mode)
            2'h0: strap_pin = 1'b0;
            2'h1: strap_pin = ind0;
            2'h2: strap_pin = ind1;
            default: strap_pin = 1'b1;
        endcase
    end

    // register file stand-in, pulse counters and a record of the line bits
    always @(negedge clk) begin
        acc_rdata <= {acc_page, 3'h0, acc_reg} ^ 16'h5a00;
        if (acc_rd === 1'b1) rd_cnt++;
        if (acc_wr === 1'b1) wr_cnt++;
    end
    always @(posedge u_mgmt_if.mdc) begin
        line_q <= {line_q[62:0], u_mgmt_if.mdio};
        mdc_rises++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic give_up(input logic ok);
        if (ok !== 1'b1) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, ok, 1'b1);
            tally_and_finish();
        end
    endtask

    // one whole frame; checks the bits seen on the line and the read result
    task automatic frame(input logic w, input logic pre, input logic [4:0] a,
                         input logic [4:0] r, input logic [15:0] d, input logic [15:0] e);
        int n;
        int r0;
        logic [1:0] ta;
        ta = (!w && a !== own) ? 2'h3 : 2'h2;
        @(negedge clk);
        req = 1'b1;
        we = w;
        preamble = pre;
        phy_addr = a;
        reg_addr = r;
        wdata = d;
        r0 = mdc_rises;
        @(negedge clk);
        req = 1'b0;
        `CHECK(busy, 1'b1)
        for (n = 0; n < 1000 && done !== 1'b1; n++) @(negedge clk);
        give_up(done);
        `CHECK(busy, 1'b0)
        `CHECK(mdc_rises - r0, 33 + 32 * pre)
        `CHECK(line_q[31:0], {2'h1, w ? 2'h1 : 2'h2, a, r, ta, w ? d : e})
        if (pre) `CHECK(line_q[63:32], 32'hffffffff)
        if (!w) `CHECK(rdata, e)
    endtask

    // strap tie decoded after reset release, then shown in the select register
    task automatic t_strap(input logic [1:0] mode);
        int n;
        @(negedge clk);
        arst_n = 1'b0;
        strap_mode = mode;
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        own = {4'h0, mode[0]};
        `CHECK(io_sel, 1'b0)
        `CHECK(st_addr, 5'h00)
        for (n = 0; n < 300 && strap_done !== 1'b1; n++) @(negedge clk);
        give_up(strap_done);
        `CHECK(st_addr, own)
        `CHECK(io_sel, ^mode)
        `CHECK({ind2, ind1, ind0}, 3'h0)
        frame(1'b1, 1'b0, own, 5'h16, 16'h0002, 16'h0);
        frame(1'b0, 1'b1, own, 5'h18, 16'h0, {2'h0, ^mode, 13'h0});
    endtask

    // software override of the select; page register holds the page
    task automatic t_sw_select();
        frame(1'b1, 1'b0, own, 5'h18, 16'hffff, 16'h0);
        `CHECK(io_sel, 1'b1)
        `CHECK(st_addr, own)
        frame(1'b0, 1'b0, own, 5'h18, 16'h0, 16'h2000);
        frame(1'b1, 1'b0, own, 5'h16, 16'h0005, 16'h0);
        frame(1'b0, 1'b1, own, 5'h16, 16'h0, 16'h0005);
        frame(1'b1, 1'b0, own, 5'h18, 16'h0000, 16'h0);
        `CHECK(io_sel, 1'b1)
    endtask

    // accesses outside the local registers reach the register port
    task automatic t_remote();
        int r0;
        int w0;
        r0 = rd_cnt;
        w0 = wr_cnt;
        frame(1'b1, 1'b0, own, 5'h03, 16'hbeef, 16'h0);
        `CHECK(wr_cnt, w0 + 1)
        `CHECK({acc_page, acc_reg, acc_wdata}, {8'h05, 5'h03, 16'hbeef})
        frame(1'b0, 1'b0, own, 5'h07, 16'h0, 16'h5f07);
        `CHECK(rd_cnt, r0 + 1)
        frame(1'b0, 1'b0, own, 5'h16, 16'h0, 16'h0005);
        `CHECK(rd_cnt, r0 + 1)
    endtask

    // frames for another station leave the line and the registers alone
    task automatic t_foreign();
        int r0;
        r0 = rd_cnt;
        frame(1'b0, 1'b0, own ^ 5'h01, 5'h03, 16'h0, 16'hffff);
        frame(1'b1, 1'b0, 5'h11, 5'h16, 16'h0001, 16'h0);
        frame(1'b0, 1'b0, own, 5'h16, 16'h0, 16'h0005);
        `CHECK(rd_cnt, r0)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        arst_n = 1'b0;
        strap_mode = 2'h0;
        req = 1'b0;
        we = 1'b0;
        preamble = 1'b0;
        phy_addr = 5'h00;
        reg_addr = 5'h00;
        wdata = 16'h0;
        own = 5'h00;
        {fail_count, checked} = '0;
        for (int m = 0; m < 4; m++) t_strap(2'(m));
        t_sw_select();
        t_remote();
        t_foreign();
        tally_and_finish();
    end
endmodule
